/* pkg/swd_map.svh */
// Timing constants and counter width for the supervisor watchdog
`ifndef SWD_MAP_SVH
`define SWD_MAP_SVH

// ****************************************
// Clock and timing figures
// ****************************************
`define SWD_CLK_PERIOD_NS 10
`define SWD_TIMEOUT_MS 1600
`define SWD_RECOVERY_MS 140
`define SWD_FILTER_NS 20
// Longest time rounds down; 1.6 s at 10 ns
`define SWD_TIMEOUT_CYC ((`SWD_TIMEOUT_MS * 1000000) / `SWD_CLK_PERIOD_NS)
// Least time rounds up
`define SWD_RECOVERY_CYC (((`SWD_RECOVERY_MS * 1000000) + `SWD_CLK_PERIOD_NS - 1) / `SWD_CLK_PERIOD_NS)
// Filter span: a level must hold more than this many cycles to count
`define SWD_FILTER_CYC ((`SWD_FILTER_NS + `SWD_CLK_PERIOD_NS - 1) / `SWD_CLK_PERIOD_NS)
`define SWD_CNT_W 28

`endif

/* pkg/swd_pkg.sv */
// Types shared by the supervisor watchdog files
package swd_pkg;
	typedef enum logic [1:0] {
		SWD_ST_RESET,
		SWD_ST_RECOVER,
		SWD_ST_COUNT,
		SWD_ST_ALARM
	} swd_state_t;
endpackage

/* rtl/swd_kick_filter.sv */
// Kick input glitch filter and edge detector
`timescale 1ns/1ns
module swd_kick_filter #(
	parameter int FILT_CYC = 2
) (
	input wire logic ref_clk, // System clock
	input wire logic rst_b, // Async reset, active low
	input wire logic kick_input, // Raw kick level
	input wire logic kick_float, // Kick pin undriven
	output logic kick_pulse // One pulse per valid transition
);
	import swd_pkg::*;

	typedef struct packed {
		logic level;
		logic cand;
		logic [3:0] stable;
		logic pulse;
	} swd_filt_t;

	swd_filt_t s_q;
	swd_filt_t s_d;

	// Level must stand FILT_CYC+1 cycles; activity of FILT_CYC cycles or fewer never reaches level
	always_comb begin
		s_d = s_q;
		s_d.pulse = 1'b0;
		if (kick_float) begin
			s_d.stable = 4'h0;
			s_d.cand = s_q.level;
		end else if (kick_input != s_q.cand) begin
			s_d.cand = kick_input;
			s_d.stable = 4'h1;
		end else if (s_q.cand != s_q.level) begin
			if (s_q.stable >= 4'(FILT_CYC)) begin
				s_d.level = s_q.cand;
				s_d.pulse = 1'b1;
			end else begin
				s_d.stable = s_q.stable + 4'h1;
			end
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign kick_pulse = s_q.pulse;
endmodule

/* rtl/swd_supervisor_watchdog.sv */
// Supervisor watchdog: timeout counter, supply reset and recovery timing
//
// Overview of operation
// - Each valid kick transition while counting or in alarm clears the counter and starts a fresh interval.
// - No kick for a full interval drives the active-low alarm output low.
// - Timeout interval is 1.6 seconds nominal for every variant.
// - Kick activity with periods below 20 ns is filtered and ignored.
// - Supply below threshold drives the alarm low at once.
// - While supply is low the counter holds at zero; in recovery it counts the recovery time.
// - After recovery time expires counting resumes without a kick.
// - Floating kick input disables the watchdog on 5 V variants.
// - Recovery time lasts at least 140 ms after the cause disappears.
// - Supervisor reset holds while supply low, then for the recovery time.
`timescale 1ns/1ns
`include "swd_map.svh"
module swd_supervisor_watchdog #(
	parameter int TIMEOUT_CYC = `SWD_TIMEOUT_CYC,
	parameter int RECOVERY_CYC = `SWD_RECOVERY_CYC,
	parameter int FILT_CYC = `SWD_FILTER_CYC,
	parameter bit FLOAT_DISABLE = 1'b1
) (
	input wire logic ref_clk, // 100 MHz clock
	input wire logic rst_b, // Async reset, active low
	input wire logic supply_low, // Supply below reset threshold
	input wire logic kick_input, // Kick from host
	input wire logic kick_float, // Kick pin floating or tri-stated
	output logic timeout_alarm_n, // Alarm, active low
	output logic sup_reset_n, // Supervisor reset, active low
	output swd_pkg::swd_state_t wd_state // Current watchdog state
);
	import swd_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		swd_state_t st;
		logic [`SWD_CNT_W-1:0] cnt;
		logic alarm_n;
		logic rst_n;
	} swd_core_t;

	swd_core_t s_q;
	swd_core_t s_d;
	logic kick_pulse;
	logic wd_off;

	// ****************************************
	// Kick filter
	// ****************************************
	swd_kick_filter #(
		.FILT_CYC(FILT_CYC)
	) u_filt (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.kick_input(kick_input),
		.kick_float(kick_float),
		.kick_pulse(kick_pulse)
	);

	// Floating pin holds the timeout counter at zero while counting; an alarm already standing stays low
	assign wd_off = FLOAT_DISABLE && kick_float;

	// ****************************************
	// Watchdog and recovery sequencing
	// ****************************************
	// One counter serves recovery then timeout; they never overlap
	always_comb begin
		s_d = s_q;
		case (s_q.st)
			SWD_ST_RESET: begin
				s_d.cnt = '0;
				s_d.rst_n = 1'b0;
				s_d.alarm_n = 1'b0;
				if (!supply_low) begin
					s_d.st = SWD_ST_RECOVER;
				end
			end
			SWD_ST_RECOVER: begin
				s_d.rst_n = 1'b0;
				s_d.alarm_n = 1'b0;
				if (s_q.cnt >= `SWD_CNT_W'(RECOVERY_CYC - 1)) begin
					s_d.cnt = '0;
					s_d.rst_n = 1'b1;
					s_d.alarm_n = 1'b1;
					s_d.st = SWD_ST_COUNT;
				end else begin
					s_d.cnt = s_q.cnt + 1'b1;
				end
			end
			SWD_ST_COUNT: begin
				if (kick_pulse || wd_off) begin
					s_d.cnt = '0;
				end else if (s_q.cnt >= `SWD_CNT_W'(TIMEOUT_CYC - 1)) begin
					s_d.alarm_n = 1'b0;
					s_d.st = SWD_ST_ALARM;
				end else begin
					s_d.cnt = s_q.cnt + 1'b1;
				end
			end
			SWD_ST_ALARM: begin
				if (kick_pulse) begin
					s_d.alarm_n = 1'b1;
					s_d.cnt = '0;
					s_d.st = SWD_ST_COUNT;
				end
			end
			default: begin
				s_d.st = SWD_ST_RESET;
			end
		endcase
		// Supply loss overrides every state at once
		if (supply_low) begin
			s_d.st = SWD_ST_RESET;
			s_d.cnt = '0;
			s_d.rst_n = 1'b0;
			s_d.alarm_n = 1'b0;
		end
	end

	// State register; reset behaves like power-up
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '{st: SWD_ST_RESET, cnt: '0, alarm_n: 1'b0, rst_n: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	// Alarm drops combinationally on supply loss, no cycle lost
	assign timeout_alarm_n = s_q.alarm_n && !supply_low;
	assign sup_reset_n = s_q.rst_n && !supply_low;
	assign wd_state = s_q.st;

	// ****************************************
	// Assertions
	// ****************************************
	property p_kick_clear;
		@(posedge ref_clk) disable iff (!rst_b)
		(s_q.st == SWD_ST_COUNT && kick_pulse && !supply_low) |=> (s_q.cnt == '0);
	endproperty
	a_kick_clear: assert property (p_kick_clear) else $error("kick did not clear counter");

	property p_timeout;
		@(posedge ref_clk) disable iff (!rst_b)
		(s_q.st == SWD_ST_COUNT && s_q.cnt == `SWD_CNT_W'(TIMEOUT_CYC - 1) && !kick_pulse && !wd_off
			&& !supply_low) |=> !timeout_alarm_n;
	endproperty
	a_timeout: assert property (p_timeout) else $error("alarm missing at timeout");

	property p_no_early;
		@(posedge ref_clk) disable iff (!rst_b)
		(s_q.st == SWD_ST_COUNT) |-> (timeout_alarm_n || supply_low);
	endproperty
	a_no_early: assert property (p_no_early) else $error("alarm while counting");

	property p_supply_alarm;
		@(posedge ref_clk) disable iff (!rst_b)
		supply_low |-> (!timeout_alarm_n && !sup_reset_n);
	endproperty
	a_supply_alarm: assert property (p_supply_alarm) else $error("alarm high during supply loss");

	property p_hold_zero;
		@(posedge ref_clk) disable iff (!rst_b)
		supply_low |=> (s_q.cnt == '0 && s_q.st == SWD_ST_RESET);
	endproperty
	a_hold_zero: assert property (p_hold_zero) else $error("counter moved in reset");

	property p_resume;
		@(posedge ref_clk) disable iff (!rst_b)
		(s_q.st == SWD_ST_RECOVER && s_q.cnt == `SWD_CNT_W'(RECOVERY_CYC - 1) && !supply_low)
			|=> (s_q.st == SWD_ST_COUNT && sup_reset_n);
	endproperty
	a_resume: assert property (p_resume) else $error("counting did not resume");

	property p_float_off;
		@(posedge ref_clk) disable iff (!rst_b)
		(s_q.st == SWD_ST_COUNT && wd_off && !supply_low) |=> (s_q.st == SWD_ST_COUNT && s_q.cnt == '0);
	endproperty
	a_float_off: assert property (p_float_off) else $error("watchdog ran while floating");

	property p_recovery_min;
		@(posedge ref_clk) disable iff (!rst_b)
		(s_q.st == SWD_ST_RECOVER && s_q.cnt < `SWD_CNT_W'(RECOVERY_CYC - 1)) |=> !sup_reset_n;
	endproperty
	a_recovery_min: assert property (p_recovery_min) else $error("reset released early");

	property p_release;
		@(posedge ref_clk) disable iff (!rst_b)
		(s_q.st == SWD_ST_ALARM && kick_pulse && !supply_low) |=> (timeout_alarm_n && s_q.cnt == '0);
	endproperty
	a_release: assert property (p_release) else $error("kick did not release alarm");

	// Counter walks one step per idle cycle; a skipped step would shorten the interval
	property p_count_step;
		@(posedge ref_clk) disable iff (!rst_b)
		(s_q.st == SWD_ST_COUNT && !kick_pulse && !wd_off && !supply_low
			&& s_q.cnt < `SWD_CNT_W'(TIMEOUT_CYC - 1)) |=> (s_q.cnt == $past(s_q.cnt) + 1'b1);
	endproperty
	a_count_step: assert property (p_count_step) else $error("timeout counter skipped a step");

	property p_before_limit;
		@(posedge ref_clk) disable iff (!rst_b)
		(s_q.st == SWD_ST_COUNT && s_q.cnt < `SWD_CNT_W'(TIMEOUT_CYC - 1) && !supply_low)
			|=> (timeout_alarm_n || supply_low);
	endproperty
	a_before_limit: assert property (p_before_limit) else $error("alarm before full interval");

	property p_alarm_stands;
		@(posedge ref_clk) disable iff (!rst_b)
		(s_q.st == SWD_ST_ALARM && !kick_pulse) |=> !timeout_alarm_n;
	endproperty
	a_alarm_stands: assert property (p_alarm_stands) else $error("alarm released without kick");

	property p_reset_hold;
		@(posedge ref_clk) disable iff (!rst_b)
		(s_q.st == SWD_ST_RESET || s_q.st == SWD_ST_RECOVER) |-> (!sup_reset_n && !timeout_alarm_n);
	endproperty
	a_reset_hold: assert property (p_reset_hold) else $error("outputs high during reset");

	property p_recover_entry;
		@(posedge ref_clk) disable iff (!rst_b)
		(s_q.st == SWD_ST_RESET && !supply_low) |=> (s_q.st == SWD_ST_RECOVER && s_q.cnt == '0);
	endproperty
	a_recover_entry: assert property (p_recover_entry) else $error("recovery did not start");
endmodule

/* tb/swd_host_model.sv */
// Host processor model that toggles the kick pin
`timescale 1ns/1ns
module swd_host_model (
	input wire logic ref_clk, // System clock
	input wire logic rst_b, // Async reset, active low
	input wire logic [7:0] gap, // Cycles between toggles, 0 stops
	input wire logic glitch, // Short pulse overlaid on the pin
	input wire logic kick_float, // Host driver tri-stated
	output logic kick_input // Pin level seen by the watchdog
);
	// ****************************************
	// Toggle generator
	// ****************************************
	logic [7:0] cnt_q;
	logic lvl_q;
	logic wob_q;
	// Periodic toggle keeps the watchdog fed; gap 0 models a hung host
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 8'h00;
			lvl_q <= 1'b0;
			wob_q <= 1'b0;
		end else begin
			wob_q <= ~wob_q;
			if (gap != 8'h00 && cnt_q >= gap - 8'h01) begin
				cnt_q <= 8'h00;
				lvl_q <= ~lvl_q;
			end else begin
				cnt_q <= cnt_q + 8'h01;
			end
		end
	end
	// Undriven pin wobbles every cycle so no stale level is trusted
	assign kick_input = kick_float ? wob_q : (lvl_q ^ glitch);
endmodule

/* tb/testbench.sv */
// Self-checking bench for the supervisor watchdog
`timescale 1ns/1ns
`define CHK(n, e, g) begin #1; check_count++; if ((g) !== (e)) begin \
	$display("MISMATCH %s exp=%0h got=%0h", n, e, g); err_total++; end end
module testbench;
	import swd_pkg::*;
	typedef struct {logic [7:0] gap; int cyc; logic alarm_n; swd_state_t st;} swd_row_t;
	localparam int TO = 200;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic supply_low = 1'b0;
	logic kick_float = 1'b0;
	logic glitch = 1'b0;
	logic [7:0] gap = 8'h00;
	logic kick_input, timeout_alarm_n, sup_reset_n;
	swd_state_t wd_state;
	int err_total = 0;
	int check_count = 0;
	// Feed, starve, re-feed, feed near the limit
	swd_row_t rows[4] = '{'{8'h32, 600, 1'b1, SWD_ST_COUNT}, '{8'h00, 260, 1'b0, SWD_ST_ALARM},
		'{8'h32, 100, 1'b1, SWD_ST_COUNT}, '{8'hBE, 800, 1'b1, SWD_ST_COUNT}};
	// ****************************************
	// Clock, design and host
	// ****************************************
	always #5 ref_clk = ~ref_clk;
	swd_supervisor_watchdog #(.TIMEOUT_CYC(TO), .RECOVERY_CYC(50), .FILT_CYC(2), .FLOAT_DISABLE(1'b1))
		swd_supervisor_watchdog_i (.ref_clk(ref_clk), .rst_b(rst_b), .supply_low(supply_low),
		.kick_input(kick_input), .kick_float(kick_float), .timeout_alarm_n(timeout_alarm_n),
		.sup_reset_n(sup_reset_n), .wd_state(wd_state));
	swd_host_model swd_host_model_i (.ref_clk(ref_clk), .rst_b(rst_b), .gap(gap), .glitch(glitch),
		.kick_float(kick_float), .kick_input(kick_input));
	// Single exit point for verdict and hang cut-off
	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Bounded wait for a state; running out is a mismatch
	task automatic wait_st(input swd_state_t s);
		int i;
		for (i = 0; i < 1000 && wd_state !== s; i++) begin
			@(posedge ref_clk);
			#1;
		end
		if (wd_state !== s) begin
			err_total++;
			tally_and_finish();
		end
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (15) @(posedge ref_clk);
		`CHK("alarm_n", 1'b0, timeout_alarm_n)
		`CHK("sup_reset_n", 1'b0, sup_reset_n)
		@(posedge ref_clk);
		rst_b <= 1'b1;
		wait_st(SWD_ST_COUNT);
		foreach (rows[k]) begin
			@(posedge ref_clk);
			gap <= rows[k].gap;
			repeat (rows[k].cyc) @(posedge ref_clk);
			`CHK("alarm_n", rows[k].alarm_n, timeout_alarm_n)
			`CHK("state", rows[k].st, wd_state)
		end
		// Two-cycle glitch must not restart the interval
		@(posedge ref_clk);
		gap <= 8'h00;
		repeat (100) @(posedge ref_clk);
		glitch <= 1'b1;
		repeat (2) @(posedge ref_clk);
		glitch <= 1'b0;
		repeat (150) @(posedge ref_clk);
		`CHK("alarm_n", 1'b0, timeout_alarm_n)
		@(posedge ref_clk);
		gap <= 8'h32;
		repeat (100) @(posedge ref_clk);
		// Supply loss overrides everything, then recovery
		supply_low <= 1'b1;
		@(posedge ref_clk);
		`CHK("alarm_n", 1'b0, timeout_alarm_n)
		`CHK("sup_reset_n", 1'b0, sup_reset_n)
		repeat (300) @(posedge ref_clk);
		`CHK("state", SWD_ST_RESET, wd_state)
		@(posedge ref_clk);
		supply_low <= 1'b0;
		gap <= 8'h00;
		repeat (40) @(posedge ref_clk);
		`CHK("sup_reset_n", 1'b0, sup_reset_n)
		// Last cycle of recovery, then release on the very next edge
		repeat (10) @(posedge ref_clk);
		`CHK("sup_reset_n", 1'b0, sup_reset_n)
		@(posedge ref_clk);
		`CHK("sup_reset_n", 1'b1, sup_reset_n)
		wait_st(SWD_ST_COUNT);
		`CHK("sup_reset_n", 1'b1, sup_reset_n)
		repeat (TO - 5) @(posedge ref_clk);
		`CHK("alarm_n", 1'b1, timeout_alarm_n)
		repeat (10) @(posedge ref_clk);
		`CHK("alarm_n", 1'b0, timeout_alarm_n)
		// Floating kick pin stops the watchdog
		@(posedge ref_clk);
		gap <= 8'h32;
		repeat (100) @(posedge ref_clk);
		gap <= 8'h00;
		kick_float <= 1'b1;
		repeat (300) @(posedge ref_clk);
		`CHK("alarm_n", 1'b1, timeout_alarm_n)
		`CHK("state", SWD_ST_COUNT, wd_state)
		tally_and_finish();
	end
endmodule
